// ---- src/quad_wiper_serial_control_defs.svh ----
/*
 * Constants of the quad wiper serial control block: opcodes, reset
 * values, field positions and timing.
 * Assumes inclusion by bare name from the design; the package does not include it.
 */
`ifndef QUAD_WIPER_SERIAL_CONTROL_DEFS_SVH
`define QUAD_WIPER_SERIAL_CONTROL_DEFS_SVH

// Instruction opcodes, upper nibble of the instruction byte
`define OP_RD_WIPER     4'h9
`define OP_WR_WIPER     4'hA
`define OP_RD_SET       4'hB
`define OP_WR_SET       4'hC
`define OP_COPY_SET2W   4'hD
`define OP_COPY_W2SET   4'hE
`define OP_GCOPY_SET2W  4'h1
`define OP_GCOPY_W2SET  4'h8
`define OP_RD_STATUS    4'h5
`define OP_STEP         4'h2

// Field positions
`define TYPE_MSB        7
`define TYPE_LSB        4
`define SEL_ADDR_MSB    1
`define SEL_ADDR_LSB    0
`define SLOT_MSB        3
`define SLOT_LSB        2
`define WIPER_MSB       1
`define WIPER_LSB       0

// Reset values and step limits
`define SET_RESET       6'h20
`define WIPER_TOP       6'h3F
`define WIPER_BOTTOM    6'h00
`define TAP_RESET       64'h0000_0001_0000_0000

// Timing
`define T_NVW_NS        10000000
`define CLK_PERIOD_NS   8

`endif

// ---- src/quad_wiper_serial_control_pkg.sv ----
/*
 * Types of the quad wiper serial control block.
 * Assumes the defs header is on the include path.
 */
package quad_wiper_serial_control_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SEL,
    S_INSTR,
    S_DATA,
    S_STEP,
    S_DONE,
    S_IGNORE
  } serial_state_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } link_t;

endpackage

// ---- src/quad_wiper_serial_control.sv ----
/*
 * Serial slave and register logic of a quad digital potentiometer:
 * select byte check, instruction decode, four wiper position registers,
 * sixteen stored settings with a timed commit, one-hot tap enables.
 * Assumes all serial pins are asynchronous to clk_sys_i; each passes two
 * flip-flops. The serial clock must be well below clk_sys_i / 4.
 */
// Contract
// [RULE_01] Pause pin low freezes shifting, state kept
// [RULE_02] Host moves pause only while clock low
// [RULE_03] Host holds pause high when unused
// [RULE_04] Strap pins give select byte low bits
// [RULE_05] Write protect low blocks setting writes
// [RULE_06] Host keeps select low, pause/protect high
// [RULE_07] Serial input sampled on rising clock
// [RULE_08] Output three-state unless driving read data
// [RULE_09] Six bits decode one-hot to 64 taps
// [RULE_10] Wiper changed by write, copy, step, power-up
// [RULE_11] Power-up loads wiper from slot zero
// [RULE_12] Four 6-bit settings per wiper, read/write/copy
// [RULE_13] Setting write finishes within 10 ms
// [RULE_14] Commit starts at select rise after complete write
// [RULE_15] Busy flag readable through status command
// [RULE_16] First byte after select fall is select byte
// [RULE_17] Continue only when both address bits match
// [RULE_18] Host sends zeros in two middle bits
// [RULE_19] Deselected means output high impedance
// [RULE_20] Host gives one select fall after power-up
// [RULE_21] Read data shifted out on falling clock
// [RULE_22] Instruction byte: opcode, slot, wiper index
// [RULE_23] Failed select byte ignored until deselect
`timescale 1ns/100ps
`include "quad_wiper_serial_control_defs.svh"

module quad_wiper_serial_control #(
  parameter int unsigned NV_WRITE_CYC = `T_NVW_NS / `CLK_PERIOD_NS,
  // Device type code; value is arbitrary
  parameter logic [3:0]  DEV_TYPE     = 4'hA
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 sck_i,
  input  wire logic                 si_i,
  input  wire logic                 hold_n_i,
  input  wire logic                 wp_n_i,
  input  wire logic [1:0]           addr_strap_i,
  output wire logic                 so_o,
  output wire logic                 so_oe_o,
  output wire logic                 nv_write_busy_o,
  output wire logic [3:0][63:0]     tap_en_o
);
  import quad_wiper_serial_control_pkg::*;

  localparam int unsigned CW = $clog2(NV_WRITE_CYC + 1);
  localparam logic [CW-1:0] NVW_LOAD = CW'(NV_WRITE_CYC);
  localparam link_t LINK_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                  hold_n: 1'b1, wp_n: 1'b1};

  link_t               s1_q, s2_q, s3_q;
  logic [1:0]          strap1_q, strap2_q;
  serial_state_t       st_q;
  logic [2:0]          bit_cnt_q;
  logic [6:0]          sh_q;
  logic [3:0]          op_q;
  logic [1:0]          slot_q, w_q;
  logic                rd_act_q, so_q;
  logic [7:0]          out_sh_q, rd_word;
  logic [3:0][5:0]     wiper_q, w_val;
  logic [3:0]          w_mask;
  logic                pwr_load_q;
  logic [3:0][3:0][5:0] dr_q;
  logic                pend_q;
  logic [3:0]          st_mask_q;
  logic [1:0]          st_slot_q;
  logic [3:0][5:0]     st_val_q;
  logic [CW-1:0]       busy_cnt_q;
  logic [3:0][63:0]    tap_q;
  logic                sck_rise, sck_fall, cs_fall, cs_rise, done;
  logic                busy, nv_start;
  logic [7:0]          byte_in;
  logic [3:0]          op_in;
  logic [1:0]          slot_in, idx_in;

  function automatic logic is_read(input logic [3:0] op);
    return op == `OP_RD_WIPER || op == `OP_RD_SET || op == `OP_RD_STATUS;
  endfunction

  function automatic logic [63:0] onehot(input logic [5:0] v);
    return 64'h0000_0000_0000_0001 << v;
  endfunction

  function automatic serial_state_t after_instr(input logic [3:0] op);
    case (op)
      `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_SET, `OP_WR_SET,
      `OP_RD_STATUS:  return S_DATA;
      `OP_STEP:       return S_STEP;
      `OP_COPY_SET2W, `OP_COPY_W2SET, `OP_GCOPY_SET2W,
      `OP_GCOPY_W2SET: return S_DONE;
      default:        return S_IGNORE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; s3 is only an edge-detect history of s2
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q     <= LINK_IDLE;
      s2_q     <= LINK_IDLE;
      s3_q     <= LINK_IDLE;
      strap1_q <= 2'h0;
      strap2_q <= 2'h0;
    end else begin
      s1_q     <= '{cs_n: cs_n_i, sck: sck_i, si: si_i,
                    hold_n: hold_n_i, wp_n: wp_n_i};
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      strap1_q <= addr_strap_i;
      strap2_q <= strap1_q;
    end
  end

  // Pause: clock edges seen while the pause pin is low are dropped
  // [RULE_01] edge gating
  assign sck_rise = s2_q.sck & ~s3_q.sck & ~s2_q.cs_n & s2_q.hold_n;
  assign sck_fall = ~s2_q.sck & s3_q.sck & ~s2_q.cs_n & s2_q.hold_n;
  assign cs_fall  = ~s2_q.cs_n & s3_q.cs_n;
  assign cs_rise  = s2_q.cs_n & ~s3_q.cs_n;
  // [RULE_07] sample on rise
  assign byte_in  = {sh_q, s2_q.si};
  assign done     = sck_rise & (bit_cnt_q == 3'h7);
  // [RULE_22] instruction fields
  assign op_in    = byte_in[`TYPE_MSB:`TYPE_LSB];
  assign slot_in  = byte_in[`SLOT_MSB:`SLOT_LSB];
  assign idx_in   = byte_in[`WIPER_MSB:`WIPER_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Serial sequencer
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q      <= S_IDLE;
      bit_cnt_q <= 3'h0;
      sh_q      <= 7'h00;
      op_q      <= 4'h0;
      slot_q    <= 2'h0;
      w_q       <= 2'h0;
    end else if (s2_q.cs_n) begin
      st_q      <= S_IDLE;
      bit_cnt_q <= 3'h0;
    end else if (cs_fall) begin
      // [RULE_16] select byte first
      st_q      <= S_SEL;
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      sh_q      <= byte_in[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (done) begin
        case (st_q)
          S_SEL: begin
            // [RULE_04] [RULE_17] [RULE_23] type and strap check
            if (op_in == DEV_TYPE &&
                byte_in[`SEL_ADDR_MSB:`SEL_ADDR_LSB] == strap2_q) begin
              st_q <= S_INSTR;
            end else begin
              st_q <= S_IGNORE;
            end
          end
          S_INSTR: begin
            op_q   <= op_in;
            slot_q <= slot_in;
            w_q    <= idx_in;
            st_q   <= after_instr(op_in);
          end
          S_DATA:  st_q <= S_DONE;
          default: st_q <= st_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    case (op_in)
      `OP_RD_WIPER: rd_word = {2'b00, wiper_q[idx_in]};
      `OP_RD_SET:   rd_word = {2'b00, dr_q[idx_in][slot_in]};
      // [RULE_15] busy in status
      default:      rd_word = {7'h00, busy};
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_act_q <= 1'b0;
      out_sh_q <= 8'h00;
      so_q     <= 1'b0;
    end else if (s2_q.cs_n) begin
      rd_act_q <= 1'b0;
    end else if (done && st_q == S_INSTR && is_read(op_in)) begin
      rd_act_q <= 1'b1;
      out_sh_q <= rd_word;
    end else if (done && st_q == S_DATA) begin
      rd_act_q <= 1'b0;
    end else if (sck_fall && rd_act_q) begin
      // [RULE_21] shift on fall
      so_q     <= out_sh_q[7];
      out_sh_q <= {out_sh_q[6:0], 1'b0};
    end
  end

  assign so_o    = so_q;
  // [RULE_08] [RULE_19] drive only read data
  assign so_oe_o = rd_act_q;

  ////////////////////////////////////////////////////////////////////////
  // Wiper position registers
  always_comb begin
    w_mask = 4'h0;
    w_val  = '0;
    if (done && st_q == S_INSTR && op_in == `OP_COPY_SET2W) begin
      w_mask[idx_in] = 1'b1;
      w_val[idx_in]  = dr_q[idx_in][slot_in];
    end else if (done && st_q == S_INSTR && op_in == `OP_GCOPY_SET2W) begin
      w_mask = 4'hF;
      for (int i = 0; i < 4; i++) begin
        w_val[i] = dr_q[i][slot_in];
      end
    end else if (done && st_q == S_DATA && op_q == `OP_WR_WIPER) begin
      w_mask[w_q] = 1'b1;
      w_val[w_q]  = byte_in[5:0];
    end else if (sck_rise && st_q == S_STEP) begin
      // Steps saturate at either end of the array
      w_mask[w_q] = 1'b1;
      if (s2_q.si) begin
        w_val[w_q] = (wiper_q[w_q] == `WIPER_TOP) ? `WIPER_TOP
                                                  : wiper_q[w_q] + 6'h01;
      end else begin
        w_val[w_q] = (wiper_q[w_q] == `WIPER_BOTTOM) ? `WIPER_BOTTOM
                                                     : wiper_q[w_q] - 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wiper_q    <= {4{`SET_RESET}};
      pwr_load_q <= 1'b1;
    end else begin
      pwr_load_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        if (pwr_load_q) begin
          // [RULE_11] load slot zero
          wiper_q[i] <= dr_q[i][0];
        end else if (w_mask[i]) begin
          // [RULE_10] write, copy or step
          wiper_q[i] <= w_val[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stored settings and the timed commit
  assign busy            = busy_cnt_q != '0;
  assign nv_write_busy_o = busy;
  // [RULE_05] [RULE_14] commit at deselect
  assign nv_start = cs_rise & pend_q & s2_q.wp_n & ~busy;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dr_q       <= {16{`SET_RESET}};
      pend_q     <= 1'b0;
      st_mask_q  <= 4'h0;
      st_slot_q  <= 2'h0;
      st_val_q   <= '0;
      busy_cnt_q <= '0;
    end else begin
      // [RULE_13] busy window
      if (nv_start) begin
        busy_cnt_q <= NVW_LOAD;
      end else if (busy) begin
        busy_cnt_q <= busy_cnt_q - CW'(1);
      end
      if (cs_rise) begin
        pend_q <= 1'b0;
        if (nv_start) begin
          // [RULE_12] update stored settings
          for (int i = 0; i < 4; i++) begin
            if (st_mask_q[i]) begin
              dr_q[i][st_slot_q] <= st_val_q[i];
            end
          end
        end
      end else if (done && st_q == S_INSTR &&
                   (op_in == `OP_COPY_W2SET ||
                    op_in == `OP_GCOPY_W2SET)) begin
        pend_q    <= 1'b1;
        st_slot_q <= slot_in;
        st_val_q  <= wiper_q;
        st_mask_q <= (op_in == `OP_GCOPY_W2SET) ? 4'hF
                                                 : 4'(1 << idx_in);
      end else if (done && st_q == S_DATA && op_q == `OP_WR_SET) begin
        pend_q        <= 1'b1;
        st_slot_q     <= slot_q;
        st_val_q[w_q] <= byte_in[5:0];
        st_mask_q     <= 4'(1 << w_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tap decode, registered
  for (genvar g = 0; g < 4; g++) begin : g_tap
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        tap_q[g] <= `TAP_RESET;
      end else begin
        // [RULE_09] one-hot tap
        tap_q[g] <= onehot(wiper_q[g]);
      end
    end
    tap_onehot_a: assert property (@(posedge clk_sys_i) // [RULE_09]
      disable iff (!nrst_i)
      $onehot(tap_q[g]) ##1 (tap_q[g] == onehot($past(wiper_q[g]))))
      else $error("tap enable not one-hot of wiper");
  end
  assign tap_en_o = tap_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  hold_freeze_a: assert property (@(posedge clk_sys_i) // [RULE_01]
    disable iff (!nrst_i)
    (!s2_q.hold_n && !s2_q.cs_n) ##1 (!s2_q.hold_n && !s2_q.cs_n)
    |-> $stable(bit_cnt_q) && $stable(st_q))
    else $error("sequence moved during pause");
  sel_check_a: assert property (@(posedge clk_sys_i) // [RULE_17]
    disable iff (!nrst_i)
    (st_q == S_SEL && done && (op_in != DEV_TYPE ||
     byte_in[`SEL_ADDR_MSB:`SEL_ADDR_LSB] != strap2_q))
    |=> st_q == S_IGNORE)
    else $error("bad select byte accepted");
  ignore_quiet_a: assert property (@(posedge clk_sys_i) // [RULE_23]
    disable iff (!nrst_i)
    st_q == S_IGNORE |-> !so_oe_o && w_mask == 4'h0)
    else $error("ignored sequence had effect");
  idle_tristate_a: assert property (@(posedge clk_sys_i) // [RULE_19]
    disable iff (!nrst_i)
    s2_q.cs_n |=> !so_oe_o)
    else $error("output driven while deselected");
  wp_block_a: assert property (@(posedge clk_sys_i) // [RULE_05]
    disable iff (!nrst_i)
    (cs_rise && !s2_q.wp_n && !busy) |=> !busy && $stable(dr_q))
    else $error("protected write committed");
  commit_cs_a: assert property (@(posedge clk_sys_i) // [RULE_14]
    disable iff (!nrst_i)
    $rose(busy) |-> $past(cs_rise) && $past(pend_q))
    else $error("commit without deselect");
  busy_len_a: assert property (@(posedge clk_sys_i) // [RULE_13]
    disable iff (!nrst_i)
    $rose(busy) |-> busy_cnt_q == NVW_LOAD ##1 busy_cnt_q == NVW_LOAD - 1)
    else $error("busy window wrong length");
  pwrup_load_a: assert property (@(posedge clk_sys_i) // [RULE_11]
    disable iff (!nrst_i)
    $fell(pwr_load_q) |-> wiper_q[0] == $past(dr_q[0][0]) &&
    wiper_q[3] == $past(dr_q[3][0]))
    else $error("power-up load missing");
  step_up_a: assert property (@(posedge clk_sys_i) // [RULE_10]
    disable iff (!nrst_i)
    (sck_rise && st_q == S_STEP && s2_q.si && wiper_q[w_q] != `WIPER_TOP)
    |=> wiper_q[w_q] == 6'($past(wiper_q[w_q]) + 6'h01))
    else $error("increment step wrong");
  so_fall_a: assert property (@(posedge clk_sys_i) // [RULE_21]
    disable iff (!nrst_i)
    $changed(so_q) |-> $past(sck_fall) && $past(rd_act_q))
    else $error("output changed off falling clock");

endmodule

// ---- tb/spi_host_model.sv ----
/* Host master model: select frames, MSB-first bytes, pause.
   Assumes the bench calls one task at a time. */
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic                            clk_sys_i,
  input  wire logic                            so_i,
  input  wire logic                            so_oe_i,
  output quad_wiper_serial_control_pkg::link_t link_o
);
  import quad_wiper_serial_control_pkg::*;
  localparam realtime HP = 62.5;
  logic last_q = 1'b0;
  logic so_line;
  // Released line shows inverse of last value, never a stale copy
  assign so_line = so_oe_i ? so_i : ~last_q;
  always @(posedge clk_sys_i) if (so_oe_i) last_q <= so_i;
  //////////////////////////////////////////////////////////////
  // Pause idle high
  initial link_o = 5'h13;
  task automatic set_wp(input logic v);
    link_o.wp_n = v;
  endtask
  // Each operation opens with a select fall
  task automatic open_frame();
    @(negedge clk_sys_i);
    // Off-grid skew keeps every later pin move clear of clk_sys_i edges
    #0.2;
    link_o.cs_n = 1'b0;
    #HP;
  endtask
  // Select held low until the frame ends
  task automatic close_frame();
    #HP;
    link_o.cs_n = 1'b1;
    #(4*HP);
  endtask
  // Pause moved only while the clock is low
  task automatic xfer(input logic [7:0] tx, input int pause_at,
                      output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (i == pause_at) begin
        // Let the clock settle low before pausing
        #HP;
        link_o.hold_n = 1'b0;
        #(8*HP);
        link_o.hold_n = 1'b1;
        #HP;
      end
      link_o.si = tx[i];
      #HP;
      link_o.sck = 1'b1;
      rx[i] = so_line;
      #HP;
      link_o.sck = 1'b0;
    end
  endtask
endmodule

// ---- tb/quad_wiper_serial_control_bench.sv ----
/* Self-checking bench of the quad wiper serial control block.
   Assumes design and host model are compiled first. */
`timescale 1ns/100ps
module quad_wiper_serial_control_bench;
  import quad_wiper_serial_control_pkg::*;
  // Short commit window so status reads still see it busy
  localparam int NVW = 600;
  // Device type; value is arbitrary
  localparam logic [3:0] DEV = 4'hA;
  logic             clk_sys_i, nrst_i, so_o, so_oe_o, busy, oe_seen;
  logic [1:0]       strap;
  logic [3:0][63:0] tap;
  logic [15:0]      rnd;
  logic [7:0]       rx;
  link_t            lk;
  int               nv_write_busy[4];
  int               nv[4][4];
  int               bad_count, checks_done, cyc;

  quad_wiper_serial_control #(.NV_WRITE_CYC(NVW), .DEV_TYPE(DEV)) dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cs_n_i(lk.cs_n),
    .sck_i(lk.sck), .si_i(lk.si), .hold_n_i(lk.hold_n),
    .wp_n_i(lk.wp_n), .addr_strap_i(strap), .so_o(so_o),
    .so_oe_o(so_oe_o), .nv_write_busy_o(busy), .tap_en_o(tap));
  spi_host_model host (.clk_sys_i(clk_sys_i), .so_i(so_o),
    .so_oe_i(so_oe_o), .link_o(lk));
  //////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (so_oe_o === 1'b1) oe_seen <= 1'b1;
    if (cyc == 80000) begin
      bad_count++;
      complete_run();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] sel(input logic [1:0] a);
    return {DEV, 2'h0, a};
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] s, ins, input bit three,
                     input logic [7:0] d, input int p);
    logic [7:0] x;
    host.open_frame();
    host.xfer(s, 8, x);
    host.xfer(ins, 8, x);
    if (three) host.xfer(d, p, rx);
    host.close_frame();
  endtask
  task automatic taps();
    for (int w = 0; w < 4; w++)
      chk("tap", 64'h1 << nv_write_busy[w], tap[w]);
  endtask
  task automatic settle();
    for (int i = 0; i < NVW + 100 && busy !== 1'b0; i++)
      @(negedge clk_sys_i);
    chk("busy end", 1'b0, busy);
  endtask
  task automatic do_reset();
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    for (int w = 0; w < 4; w++) begin
      nv_write_busy[w] = 32'h20;
      for (int s = 0; s < 4; s++) nv[w][s] = 32'h20;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    nrst_i = 1'b0;
    strap = 2'h2;
    rnd = 16'h1FBF;
    oe_seen = 1'b0;
    cyc = 0;
    do_reset();
    taps();
    for (int w = 0; w < 4; w++) begin
      rnd = lfsr(rnd);
      cmd(sel(strap), {6'h28, 2'(w)}, 1, {2'h3, rnd[5:0]}, 8);
      nv_write_busy[w] = rnd[5:0];
      taps();
      cmd(sel(strap), {6'h24, 2'(w)}, 1, 8'h00, w == 1 ? 4 : 8);
      chk("wiper read", nv_write_busy[w], rx);
      chk("oe idle", 1'b0, so_oe_o);
    end
    $display("test wiper_rw done");
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      if (k == 2) host.set_wp(1'b0);
      cmd(sel(strap), {4'hC, rnd[9:6]}, 1, {2'h0, rnd[5:0]},
          k == 1 ? 3 : 8);
      chk("busy", k != 2, busy);
      if (k != 2) nv[rnd[7:6]][rnd[9:8]] = rnd[5:0];
      host.set_wp(1'b1);
      cmd(sel(strap), 8'h50, 1, 8'h00, 8);
      chk("status", k != 2, rx);
      settle();
      cmd(sel(strap), {4'hB, rnd[9:6]}, 1, 8'h00, 8);
      chk("setting read", nv[rnd[7:6]][rnd[9:8]], rx);
    end
    $display("test setting_write done");
    rnd = lfsr(rnd);
    cmd(sel(strap), {4'hD, rnd[3:0]}, 0, 8'h00, 8);
    nv_write_busy[rnd[1:0]] = nv[rnd[1:0]][rnd[3:2]];
    taps();
    cmd(sel(strap), {4'hE, rnd[7:4]}, 0, 8'h00, 8);
    nv[rnd[5:4]][rnd[7:6]] = nv_write_busy[rnd[5:4]];
    settle();
    cmd(sel(strap), {4'h8, rnd[9:8], 2'h0}, 0, 8'h00, 8);
    for (int w = 0; w < 4; w++) nv[w][rnd[9:8]] = nv_write_busy[w];
    settle();
    cmd(sel(strap), {4'h1, rnd[11:10], 2'h0}, 0, 8'h00, 8);
    for (int w = 0; w < 4; w++) nv_write_busy[w] = nv[w][rnd[11:10]];
    taps();
    cmd(sel(strap), {4'hB, rnd[7:4]}, 1, 8'h00, 8);
    chk("copy read", nv[rnd[5:4]][rnd[7:6]], rx);
    $display("test copies done");
    cmd(sel(strap), 8'hA1, 1, 8'h3C, 8);
    cmd(sel(strap), 8'h21, 1, 8'hFE, 8);
    nv_write_busy[1] = 62;
    taps();
    cmd(sel(strap), 8'hA1, 1, 8'h02, 8);
    cmd(sel(strap), 8'h21, 1, 8'h01, 8);
    nv_write_busy[1] = 1;
    taps();
    $display("test step done");
    oe_seen = 1'b0;
    cmd(sel(~strap), 8'h90, 1, 8'h00, 8);
    cmd({~DEV, 2'h0, strap}, 8'hA0, 1, 8'h07, 8);
    cmd(sel(strap ^ 2'h1), 8'hA0, 1, 8'h07, 8);
    // Opcode 3 is not decoded; the data byte must change nothing
    cmd(sel(strap), 8'h31, 1, 8'h07, 8);
    chk("oe refused", 1'b0, oe_seen);
    taps();
    strap = ~strap;
    repeat (4) @(negedge clk_sys_i);
    cmd(sel(strap), 8'hA0, 1, 8'h05, 8);
    nv_write_busy[0] = 5;
    taps();
    $display("test select done");
    @(negedge clk_sys_i);
    do_reset();
    taps();
    $display("test reload done");
    complete_run();
  end
endmodule
